// ---- card_activation_sequencer.sv ----
// Five-slot card activation, reset timing and deactivation sequencer
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/1ns

module card_activation_sequencer #(
  parameter int unsigned NUM_SLOT = 5
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              clk_en,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [7:0]        paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [1:0]        card_presence_pin,
  input  wire logic              aux_supply_good,
  input  wire logic [4:0]        card_voltage_good,
  input  wire logic              overcurrent_pin,
  input  wire logic [4:0]        card_io_in,
  input  wire logic              internal_card_clock,
  input  wire logic              address_clock_input,
  input  wire logic              sequencer_clock,
  input  wire logic              power_warn_level,
  input  wire logic              power_fail_level,
  output logic [4:0][1:0]        card_voltage_select,
  output logic [4:0]             card_reset_pin,
  output logic [4:0]             card_clock_pin,
  output logic [4:0]             card_io_out,
  output logic [4:0]             card_io_oe_n,
  output logic                   irq_n
);

  // ==========================================================================
  // Parameter check
  if (NUM_SLOT != card_seq_pkg::NUM_SLOT) begin : g_bad_slots
    $error("Slot count must match the fixed five-slot layout");
  end

  // ==========================================================================
  // State
  typedef struct packed {
    card_seq_pkg::slot_s [4:0]                 sl;
    logic [card_seq_pkg::SYNC_W-1:0]           s1;
    logic [card_seq_pkg::SYNC_W-1:0]           s2;
    logic [card_seq_pkg::SYNC_W-1:0]           s3;
    logic                                      prim_off;
    logic                                      sec_off;
    logic                                      aux_flag;
    logic                                      addr_div;
    logic                                      strap;
    logic [1:0]                                strap_wait;
    logic                                      pready;
    logic                                      pslverr;
    logic [31:0]                               prdata;
    logic                                      irq_n;
  } state_s;

  state_s                          q;
  state_s                          d;
  logic [card_seq_pkg::SYNC_W-1:0] raw;
  logic [card_seq_pkg::SYNC_W-1:0] rise;
  logic [card_seq_pkg::SYNC_W-1:0] fall;
  logic                            setup;
  logic                            done;
  logic                            wr;
  logic                            rd;
  logic [2:0]                      sidx;
  logic [3:0]                      soff;
  logic                            in_slots;
  logic [32:0]                     rword;

  assign raw = {power_fail_level, power_warn_level, sequencer_clock,
                address_clock_input, internal_card_clock, card_io_in,
                overcurrent_pin, card_voltage_good, aux_supply_good,
                card_presence_pin};
  assign rise     = q.s2 & ~q.s3;
  assign fall     = ~q.s2 & q.s3;
  assign setup    = psel & ~penable;
  assign done     = psel & penable & q.pready;
  assign wr       = done & pwrite;
  assign rd       = done & ~pwrite;
  assign sidx     = paddr[6:4];
  assign soff     = paddr[3:0];
  assign in_slots = (paddr < card_seq_pkg::GLOB_CTRL) && (paddr[1:0] == 2'h0);

  // ==========================================================================
  // Register read mux: bit 32 marks a mapped address
  function automatic logic [32:0] read_word(input state_s s,
                                            input logic [7:0] a);
    logic [32:0]         r;
    card_seq_pkg::slot_s x;
    r = '0;
    x = s.sl[0];
    if (a < card_seq_pkg::GLOB_CTRL && a[1:0] == 2'h0) begin
      x = s.sl[a[6:4]];
      r[32] = 1'b1;
      case (a[3:0])
        card_seq_pkg::SLOT_CFG: begin
          r[card_seq_pkg::CF_VSEL +: 2] = x.vsel;
          r[card_seq_pkg::CF_ART]       = x.auto_reset_timing_enable;
          r[card_seq_pkg::CF_RST]       = x.rst_bit;
          r[card_seq_pkg::CF_IOEN]      = x.io_en;
          r[card_seq_pkg::CF_CLK]       = x.clk_bit;
          r[card_seq_pkg::CF_HALT]      = x.halt;
          r[card_seq_pkg::CF_IODIS]     = x.iodis;
          r[card_seq_pkg::CF_CKS +: 3]  = x.cks;
          r[card_seq_pkg::CF_MASK]      = x.mask;
        end
        card_seq_pkg::SLOT_FLAG: begin
          r[4:0] = x.flags;
          if (a[6:4] < 3'h2) begin
            r[card_seq_pkg::ST_PRES] = s.s2[card_seq_pkg::SI_PRES +
                                            32'(a[6:4])];
          end
          r[card_seq_pkg::ST_VGOOD] = s.s2[card_seq_pkg::SI_VGD +
                                           32'(a[6:4])];
          r[card_seq_pkg::ST_DEAC]  = (x.st == card_seq_pkg::SEQ_DEACT);
        end
        card_seq_pkg::SLOT_DELAY: r[15:0] = x.delay;
        card_seq_pkg::SLOT_CAPT:  r[15:0] = x.capt;
        default: r[32] = 1'b0;
      endcase
      if (a[6:4] >= 3'h5) begin
        r = '0;
      end
    end else if (a == card_seq_pkg::GLOB_CTRL) begin
      r[32]                    = 1'b1;
      r[card_seq_pkg::GC_PRIM] = s.prim_off;
      r[card_seq_pkg::GC_SEC]  = s.sec_off;
      r[card_seq_pkg::GS_AUX]  = s.s2[card_seq_pkg::SI_AUX];
    end else if (a == card_seq_pkg::GLOB_FLAG) begin
      r[32] = 1'b1;
      r[0]  = s.aux_flag;
    end else if (a == card_seq_pkg::GLOB_STRAP) begin
      r[32] = 1'b1;
      r[0]  = s.strap;
    end
    return r;
  endfunction

  assign rword = read_word(q, paddr);

  // ==========================================================================
  // Next state
  always_comb begin
    logic       trig;
    logic       active;
    logic       emerg;
    logic       any;
    logic       gate;
    logic       slot_wr;
    logic       src;
    logic [5:0] nstep;
    d       = q;
    trig    = 1'b0;
    active  = 1'b0;
    any     = 1'b0;
    emerg   = 1'b0;
    gate    = 1'b0;
    slot_wr = 1'b0;
    src     = 1'b0;
    nstep   = '0;
    d.s1    = raw;
    d.s2    = q.s1;
    d.s3    = q.s2;

    // Address strap caught once the synchroniser holds the pin level
    if (q.strap_wait != 2'h3) begin
      d.strap      = q.s2[card_seq_pkg::SI_ACLK];
      d.strap_wait = q.strap_wait + 2'h1;
    end
    if (rise[card_seq_pkg::SI_ACLK]) begin
      d.addr_div = ~q.addr_div;
    end

    // APB slave: one wait-free access phase
    d.pready = setup;
    if (setup) begin
      d.prdata  = rword[31:0];
      d.pslverr = ~rword[32];
    end
    if (wr && paddr == card_seq_pkg::GLOB_CTRL) begin
      d.prim_off = pwdata[card_seq_pkg::GC_PRIM];
      d.sec_off  = pwdata[card_seq_pkg::GC_SEC];
    end
    if (rd && paddr == card_seq_pkg::GLOB_FLAG) begin
      d.aux_flag = 1'b0;
    end
    if (rise[card_seq_pkg::SI_AUX]) begin
      d.aux_flag = 1'b1;
    end
    emerg = (wr && paddr == card_seq_pkg::GLOB_CTRL &&
             pwdata[card_seq_pkg::GC_SRST]) ||
            rise[card_seq_pkg::SI_FAIL];

    for (int i = 0; i < 5; i++) begin
      slot_wr = wr && in_slots && sidx == 3'(i);
      if (rd && in_slots && sidx == 3'(i) &&
          soff == card_seq_pkg::SLOT_FLAG) begin
        d.sl[i].flags = '0;
      end
      if (slot_wr && soff == card_seq_pkg::SLOT_FLAG) begin
        d.sl[i].flags = d.sl[i].flags | pwdata[4:0];
      end
      if (slot_wr && soff == card_seq_pkg::SLOT_DELAY) begin
        d.sl[i].delay = pwdata[15:0];
      end
      if (slot_wr && soff == card_seq_pkg::SLOT_CFG &&
          q.sl[i].st != card_seq_pkg::SEQ_DEACT) begin
        // presence gates slots 1 and 2
        // aux supply gates slots 3 to 5
        gate = (i < 2) ? q.s2[card_seq_pkg::SI_PRES + i]
                       : q.s2[card_seq_pkg::SI_AUX];
        if (pwdata[card_seq_pkg::CF_VSEL +: 2] == 2'h0 || gate) begin
          d.sl[i].vsel = pwdata[card_seq_pkg::CF_VSEL +: 2];
        end
        d.sl[i].auto_reset_timing_enable     = pwdata[card_seq_pkg::CF_ART];
        d.sl[i].rst_bit = pwdata[card_seq_pkg::CF_RST];
        d.sl[i].io_en   = pwdata[card_seq_pkg::CF_IOEN];
        d.sl[i].clk_bit = pwdata[card_seq_pkg::CF_CLK];
        d.sl[i].halt    = pwdata[card_seq_pkg::CF_HALT];
        d.sl[i].iodis   = pwdata[card_seq_pkg::CF_IODIS];
        d.sl[i].cks     = pwdata[card_seq_pkg::CF_CKS +: 3];
        d.sl[i].mask    = pwdata[card_seq_pkg::CF_MASK];
      end

      // Hardware events set flags after any clear
      if (i < 2 && (rise[card_seq_pkg::SI_PRES + i] ||
                    fall[card_seq_pkg::SI_PRES + i])) begin
        d.sl[i].flags[card_seq_pkg::FL_INS] = 1'b1;
      end
      if (rise[card_seq_pkg::SI_VGD + i]) begin
        d.sl[i].flags[card_seq_pkg::FL_VSET] = 1'b1;
      end
      if (fall[card_seq_pkg::SI_VGD + i] && q.sl[i].vsel != 2'h0) begin
        d.sl[i].flags[card_seq_pkg::FL_VFLT] = 1'b1;
      end
      if (i == 0 && rise[card_seq_pkg::SI_OCUR]) begin
        d.sl[i].flags[card_seq_pkg::FL_OCUR] = 1'b1;
      end

      active = (q.sl[i].st != card_seq_pkg::SEQ_DEACT) &&
               (d.sl[i].vsel != 2'h0);
      trig = d.sl[i].flags[card_seq_pkg::FL_VFLT] ||
             rise[card_seq_pkg::SI_WARN] ||
             (i < 2 && d.sl[i].flags[card_seq_pkg::FL_INS] &&
              !q.s2[card_seq_pkg::SI_PRES + i]) ||
             (i == 0 && (rise[card_seq_pkg::SI_OCUR] || d.prim_off)) ||
             (i > 0 && d.sec_off);

      if (active && trig) begin
        d.sl[i].st      = card_seq_pkg::SEQ_DEACT;
        d.sl[i].step    = '0;
        d.sl[i].rst_bit = 1'b0;
        d.sl[i].rst_pin = 1'b0;
        d.sl[i].cnt     = '0;
        if (i == 0) begin
          d.prim_off = 1'b1;
        end
      end else begin
        case (q.sl[i].st)
          card_seq_pkg::SEQ_IDLE: begin
            if (!(d.sl[i].auto_reset_timing_enable && d.sl[i].rst_bit)) begin
              d.sl[i].armed = 1'b0;
            end
            if (!d.sl[i].auto_reset_timing_enable) begin
              d.sl[i].rst_pin = d.sl[i].rst_bit;
            end else if (d.sl[i].rst_bit && !q.sl[i].armed) begin
              d.sl[i].armed   = 1'b1;
              d.sl[i].st      = card_seq_pkg::SEQ_RST_LOW;
              d.sl[i].cnt     = '0;
              d.sl[i].rst_pin = 1'b0;
            end
          end
          card_seq_pkg::SEQ_RST_LOW: begin
            if (!(d.sl[i].auto_reset_timing_enable && d.sl[i].rst_bit)) begin
              d.sl[i].st = card_seq_pkg::SEQ_IDLE;
            end else if (fall[card_seq_pkg::SI_IO + i] &&
                         q.sl[i].cnt >= card_seq_pkg::ATR_IGNORE) begin
              d.sl[i].capt = q.sl[i].cnt;
              d.sl[i].st   = card_seq_pkg::SEQ_IDLE;
            end else if (rise[card_seq_pkg::SI_CCLK]) begin
              if (q.sl[i].cnt == q.sl[i].delay) begin
                d.sl[i].rst_pin = 1'b1;
                d.sl[i].cnt     = '0;
                d.sl[i].st      = card_seq_pkg::SEQ_RST_HIGH;
              end else begin
                d.sl[i].cnt = q.sl[i].cnt + 16'h0001;
              end
            end
          end
          card_seq_pkg::SEQ_RST_HIGH: begin
            if (fall[card_seq_pkg::SI_IO + i]) begin
              d.sl[i].capt = q.sl[i].cnt;
              d.sl[i].st   = card_seq_pkg::SEQ_IDLE;
            end else if (rise[card_seq_pkg::SI_CCLK]) begin
              if (q.sl[i].cnt == card_seq_pkg::CNT_MAX) begin
                d.sl[i].flags[card_seq_pkg::FL_AERR] = 1'b1;
                d.sl[i].st = card_seq_pkg::SEQ_IDLE;
              end else begin
                d.sl[i].cnt = q.sl[i].cnt + 16'h0001;
              end
            end
          end
          card_seq_pkg::SEQ_DEACT: begin
            if (rise[card_seq_pkg::SI_SEQ]) begin
              nstep        = q.sl[i].step + 6'h01;
              d.sl[i].step = nstep;
              // address clock source stops at 5.5 units
              if (nstep == ((q.sl[i].cks == card_seq_pkg::CKS_ADDR ||
                             q.sl[i].cks == card_seq_pkg::CKS_ADDR_DIV) ?
                            card_seq_pkg::STEP_STOP_A :
                            card_seq_pkg::STEP_STOP)) begin
                d.sl[i].clk_bit = 1'b0;
                d.sl[i].halt    = 1'b1;
                d.sl[i].io_en   = 1'b1;
                d.sl[i].iodis   = 1'b1;
              end
              if (nstep == card_seq_pkg::STEP_IOCLR) begin
                d.sl[i].io_en = 1'b0;
              end
              if (nstep == card_seq_pkg::STEP_VOFF) begin
                d.sl[i].vsel = 2'h0;
                d.sl[i].st   = card_seq_pkg::SEQ_IDLE;
                d.sl[i].step = '0;
              end
            end
          end
          default: d.sl[i].st = card_seq_pkg::SEQ_IDLE;
        endcase
      end

      if (emerg) begin
        d.sl[i].st      = card_seq_pkg::SEQ_IDLE;
        d.sl[i].vsel    = 2'h0;
        d.sl[i].rst_bit = 1'b0;
        d.sl[i].rst_pin = 1'b0;
        d.sl[i].clk_bit = 1'b0;
        d.sl[i].halt    = 1'b1;
        d.sl[i].io_en   = 1'b0;
        d.sl[i].iodis   = 1'b1;
        d.sl[i].armed   = 1'b0;
        d.sl[i].step    = '0;
        if (i == 0) begin
          d.prim_off = 1'b1;
        end
      end

      case (d.sl[i].cks)
        card_seq_pkg::CKS_ADDR:     src = q.s2[card_seq_pkg::SI_ACLK];
        card_seq_pkg::CKS_ADDR_DIV: src = q.addr_div;
        default:                    src = q.s2[card_seq_pkg::SI_CCLK];
      endcase
      d.sl[i].clk_pin = d.sl[i].clk_bit & ~d.sl[i].halt & src;
      d.sl[i].io_lvl  = 1'b0;

      // any flag pulls the interrupt low
      // slots 2 to 5 may be masked
      if (i == 0 || !d.sl[i].mask) begin
        any = any | (|d.sl[i].flags);
      end
    end
    d.irq_n = ~(any | d.aux_flag);
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.irq_n <= 1'b1;
      for (int i = 0; i < 5; i++) begin
        q.sl[i].delay <= card_seq_pkg::DELAY_RESET;
        q.sl[i].halt  <= 1'b1;
        q.sl[i].iodis <= 1'b1;
      end
    end else if (clk_en) begin
      q <= d;
    end
  end

  // ==========================================================================
  // Outputs
  assign prdata  = q.prdata;
  assign pready  = q.pready;
  assign pslverr = q.pslverr;
  assign irq_n   = q.irq_n;
  for (genvar g = 0; g < 5; g++) begin : g_out
    assign card_voltage_select[g] = q.sl[g].vsel;
    assign card_reset_pin[g]      = q.sl[g].rst_pin;
    assign card_clock_pin[g]      = q.sl[g].clk_pin;
    assign card_io_out[g]         = q.sl[g].io_lvl;
    assign card_io_oe_n[g]        = q.sl[g].io_en;
  end

endmodule

// ---- card_seq_pkg.sv ----
// Constants, register map and state types for the card activation sequencer
package card_seq_pkg;

  // ==========================================================================
  // Sizes
  localparam int unsigned NUM_SLOT = 5;
  localparam int unsigned CNT_W    = 16;
  localparam int unsigned SYNC_W   = 19;

  // ==========================================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] SLOT_STRIDE = 8'h10;
  localparam logic [3:0] SLOT_CFG    = 4'h0;
  localparam logic [3:0] SLOT_FLAG   = 4'h4;
  localparam logic [3:0] SLOT_DELAY  = 4'h8;
  localparam logic [3:0] SLOT_CAPT   = 4'hc;
  localparam logic [7:0] GLOB_CTRL   = 8'h50;
  localparam logic [7:0] GLOB_FLAG   = 8'h54;
  localparam logic [7:0] GLOB_STRAP  = 8'h58;

  // ==========================================================================
  // Slot configuration field positions
  localparam int unsigned CF_VSEL  = 0;
  localparam int unsigned CF_ART   = 2;
  localparam int unsigned CF_RST   = 3;
  localparam int unsigned CF_IOEN  = 4;
  localparam int unsigned CF_CLK   = 5;
  localparam int unsigned CF_HALT  = 6;
  localparam int unsigned CF_IODIS = 7;
  localparam int unsigned CF_CKS   = 8;
  localparam int unsigned CF_MASK  = 11;

  // Slot flag bits (read clears) and status bits
  localparam int unsigned FL_INS   = 0;
  localparam int unsigned FL_VSET  = 1;
  localparam int unsigned FL_OCUR  = 2;
  localparam int unsigned FL_VFLT  = 3;
  localparam int unsigned FL_AERR  = 4;
  localparam int unsigned ST_PRES  = 8;
  localparam int unsigned ST_VGOOD = 9;
  localparam int unsigned ST_DEAC  = 10;

  // Global control bits
  localparam int unsigned GC_PRIM = 0;
  localparam int unsigned GC_SEC  = 1;
  localparam int unsigned GC_SRST = 2;
  localparam int unsigned GS_AUX  = 8;

  // ==========================================================================
  // Synchroniser bit positions
  localparam int unsigned SI_PRES = 0;
  localparam int unsigned SI_AUX  = 2;
  localparam int unsigned SI_VGD  = 3;
  localparam int unsigned SI_OCUR = 8;
  localparam int unsigned SI_IO   = 9;
  localparam int unsigned SI_CCLK = 14;
  localparam int unsigned SI_ACLK = 15;
  localparam int unsigned SI_SEQ  = 16;
  localparam int unsigned SI_WARN = 17;
  localparam int unsigned SI_FAIL = 18;

  // ==========================================================================
  // Reset values and timing
  localparam logic [15:0] DELAY_RESET = 16'h0190;
  localparam logic [15:0] ATR_IGNORE  = 16'h00c8;
  localparam logic [15:0] CNT_MAX     = 16'hffff;
  localparam int unsigned TD_PERIODS  = 8;
  localparam logic [5:0] STEP_STOP    = 6'(5 * TD_PERIODS);
  localparam logic [5:0] STEP_STOP_A  = 6'(5 * TD_PERIODS + TD_PERIODS / 2);
  localparam logic [5:0] STEP_IOCLR   = 6'(6 * TD_PERIODS);
  localparam logic [5:0] STEP_VOFF    = 6'(7 * TD_PERIODS);
  localparam logic [2:0] CKS_ADDR     = 3'h1;
  localparam logic [2:0] CKS_ADDR_DIV = 3'h2;

  // ==========================================================================
  // State types
  typedef enum logic [1:0] {
    SEQ_IDLE     = 2'b00,
    SEQ_RST_LOW  = 2'b01,
    SEQ_RST_HIGH = 2'b11,
    SEQ_DEACT    = 2'b10
  } seq_e;

  typedef struct packed {
    seq_e        st;
    logic [1:0]  vsel;
    logic        auto_reset_timing_enable;
    logic        rst_bit;
    logic        io_en;
    logic        clk_bit;
    logic        halt;
    logic        iodis;
    logic [2:0]  cks;
    logic        mask;
    logic        armed;
    logic [4:0]  flags;
    logic [15:0] delay;
    logic [15:0] cnt;
    logic [15:0] capt;
    logic [5:0]  step;
    logic        rst_pin;
    logic        clk_pin;
    logic        io_lvl;
  } slot_s;

endpackage

// ---- card_seq_monitor.sv ----
// Concurrent checks on the card sequencer pins
`timescale 1ns/1ns
module card_seq_monitor (
  input wire logic            pclk,
  input wire logic            presetn,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic [1:0]      card_presence_pin,
  input wire logic            aux_supply_good,
  input wire logic            power_warn_level,
  input wire logic            power_fail_level,
  input wire logic [4:0][1:0] card_voltage_select,
  input wire logic [4:0]      card_reset_pin,
  input wire logic [4:0]      card_clock_pin,
  input wire logic            irq_n
);
  logic [4:0] von;
  always_comb
    for (int i = 0; i < 5; i++) von[i] = |card_voltage_select[i];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_pres; $rose(von[0]) |-> card_presence_pin[0]; endproperty
  a_pres: assert property (p_pres) else $error("no card");
  property p_aux; |(von[4:2] & ~$past(von[4:2])) |-> aux_supply_good;
  endproperty
  a_aux: assert property (p_aux) else $error("aux low");
  property p_rst; (card_reset_pin & ~von) == 5'h00; endproperty
  a_rst: assert property (p_rst) else $error("reset unpowered");
  property p_clk; (card_clock_pin & ~von) == 5'h00; endproperty
  a_clk: assert property (p_clk) else $error("clock unpowered");
  property p_fail; $rose(power_fail_level) |->
    ##[1:8] (card_voltage_select == 10'h000); endproperty
  a_fail: assert property (p_fail) else $error("fail ignored");
  property p_warn; $rose(power_warn_level) |->
    ##[1:8] (card_reset_pin == 5'h00); endproperty
  a_warn: assert property (p_warn) else $error("warn ignored");
  property p_idle; $rose(presetn) |-> irq_n; endproperty
  a_idle: assert property (p_idle) else $error("irq not idle");
  property p_irq; $rose(irq_n) |-> $past(psel && penable) ||
    $past(psel && penable, 2) || $past(psel && penable, 3); endproperty
  a_irq: assert property (p_irq) else $error("irq rose alone");
endmodule
bind card_activation_sequencer card_seq_monitor u_mon (.pclk, .presetn,
  .psel, .penable, .card_presence_pin, .aux_supply_good, .power_warn_level,
  .power_fail_level, .card_voltage_select, .card_reset_pin, .card_clock_pin,
  .irq_n);

// ---- card_model.sv ----
// Card side: gated card clock, answer start bit, io wire, supply good
`timescale 1ns/1ns
module card_model #(
  parameter int ANS = 50
) (
  input  wire logic            run,
  input  wire logic [4:0]      card_reset_pin,
  input  wire logic [4:0][1:0] card_voltage_select,
  input  wire logic [4:0]      card_io_out,
  input  wire logic [4:0]      card_io_oe_n,
  output logic                 internal_card_clock,
  output logic [4:0]           card_io_in,
  output logic [4:0]           card_voltage_good
);
  int   k = 0;
  logic ans = 1'b0;
  initial begin
    internal_card_clock = 1'b0;
    #7;
    forever #80 internal_card_clock = run & ~internal_card_clock;
  end
  always @(negedge internal_card_clock) begin
    k = card_reset_pin[0] ? k + 1 : 0;
    ans = card_reset_pin[0] && k > ANS;
  end
  assign card_io_in = (card_io_oe_n | card_io_out) & {4'hf, ~ans};
  always_comb
    for (int i = 0; i < 5; i++) card_voltage_good[i] = |card_voltage_select[i];
endmodule

// ---- testbench.sv ----
// Self-checking bench for the card activation sequencer
`timescale 1ns/1ns
module testbench;
  logic            pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic            aux_supply_good, power_warn_level, power_fail_level, run;
  logic            sequencer_clock, internal_card_clock, irq_n, clk_en;
  logic [1:0]      card_presence_pin;
  logic [7:0]      paddr;
  logic [31:0]     pwdata, prdata, r;
  logic [4:0]      card_voltage_good, card_io_in, card_reset_pin;
  logic [4:0]      card_clock_pin, card_io_out, card_io_oe_n;
  logic [4:0][1:0] card_voltage_select;
  int              err_total, check_count, n;
  localparam logic [40:0] ROWS [4] = '{{8'h08, 32'h190, 1'b0},
    {8'h48, 32'h190, 1'b0}, {8'h00, 32'hc0, 1'b0}, {8'h5c, 32'h0, 1'b1}};
  card_activation_sequencer DUT (.pclk, .presetn, .clk_en, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .card_presence_pin, .aux_supply_good, .card_voltage_good,
    .overcurrent_pin(1'b0), .card_io_in, .internal_card_clock,
    .address_clock_input(1'b0), .sequencer_clock, .power_warn_level,
    .power_fail_level, .card_voltage_select, .card_reset_pin,
    .card_clock_pin, .card_io_out, .card_io_oe_n, .irq_n);
  card_model CARD (.run, .card_reset_pin, .card_voltage_select, .card_io_out,
    .card_io_oe_n, .internal_card_clock, .card_io_in, .card_voltage_good);
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    sequencer_clock = 1'b0;
    forever #50 sequencer_clock = ~sequencer_clock;
  end
  task automatic chk(input logic [31:0] x, input logic [31:0] g, string s);
    check_count++;
    if (g !== x) begin
      err_total++;
      $display("wrong value %s: expected %h, seen %h", s, x, g);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic [31:0] d, input logic w);
    @(posedge pclk);
    {psel, penable, paddr, pwdata, pwrite} <= {2'b10, a, d, w};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, run} = '0;
    {card_presence_pin, aux_supply_good, power_warn_level} = '0;
    {power_fail_level, err_total, check_count} = '0;
    clk_en = 1'b1;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ROWS[i]) begin
      apb(ROWS[i][40:33], 32'h0, 1'b0);
      chk(ROWS[i][32:1], r, "reset read");
      chk({31'h0, ROWS[i][0]}, {31'h0, e}, "slave error");
    end
    apb(8'h00, 32'h1, 1'b1);
    repeat (4) @(negedge pclk);
    chk(32'h0, {30'h0, card_voltage_select[0]}, "no card");
    @(posedge pclk);
    card_presence_pin <= 2'b01;
    apb(8'h08, 32'd300, 1'b1);
    apb(8'h04, 32'h0, 1'b0);
    apb(8'h00, 32'h3d, 1'b1);
    run <= 1'b1;
    for (n = 0; card_reset_pin[0] !== 1'b1 && n < 2000; n++)
      @(negedge internal_card_clock);
    chk(32'd301, n, "reset low clocks");
    repeat (60) @(posedge internal_card_clock);
    run <= 1'b0;
    apb(8'h0c, 32'h0, 1'b0);
    chk(32'd50, r, "capture");
    apb(8'h08, 32'd250, 1'b1);
    apb(8'h00, 32'h31, 1'b1);
    @(posedge pclk);
    chk(32'h0, {31'h0, card_reset_pin[0]}, "manual reset");
    apb(8'h00, 32'h3d, 1'b1);
    run <= 1'b1;
    for (n = 0; card_reset_pin[0] !== 1'b1 && n < 2000; n++)
      @(negedge internal_card_clock);
    chk(32'd251, n, "warm reset clocks");
    repeat (60) @(posedge internal_card_clock);
    run <= 1'b0;
    apb(8'h04, 32'h4, 1'b1);
    repeat (20) @(posedge pclk);
    chk(32'h1, {30'h0, card_voltage_select[0]}, "sw overcurrent");
    chk(32'h0, {31'h0, irq_n}, "irq low");
    apb(8'h04, 32'h0, 1'b0);
    repeat (3) @(negedge pclk);
    chk(32'h1, {31'h0, irq_n}, "irq released");
    apb(8'h04, 32'h8, 1'b1);
    for (n = 0; card_voltage_select[0] !== 2'h0 && n < 99; n++)
      @(posedge sequencer_clock);
    chk(32'h1, {31'h0, n >= 56 && n <= 57}, "voltage off step");
    $display("test slot one done");
    apb(8'h20, 32'h801, 1'b1);
    @(negedge pclk);
    chk(32'h0, {30'h0, card_voltage_select[2]}, "no aux");
    @(posedge pclk);
    aux_supply_good <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(8'h54, 32'h0, 1'b0);
    chk(32'h1, r, "aux settled flag");
    apb(8'h04, 32'h0, 1'b0);
    apb(8'h20, 32'h801, 1'b1);
    repeat (8) @(posedge pclk);
    chk(32'h1, {30'h0, card_voltage_select[2]}, "aux slot on");
    chk(32'h1, {31'h0, irq_n}, "masked irq");
    apb(8'h24, 32'h0, 1'b0);
    chk(32'h2, r & 32'h2, "masked flag");
    power_warn_level <= 1'b1;
    repeat (20) @(posedge pclk);
    power_fail_level <= 1'b1;
    repeat (8) @(posedge pclk);
    chk(32'h0, {22'h0, card_voltage_select}, "all off");
    clk_en <= 1'b0;
    card_presence_pin <= 2'b00;
    repeat (6) @(posedge pclk);
    chk(32'h1, {31'h0, irq_n}, "frozen irq");
    clk_en <= 1'b1;
    repeat (6) @(posedge pclk);
    chk(32'h0, {31'h0, irq_n}, "removal irq");
    $display("test shutdown done");
    give_verdict;
  end
  initial begin
    #500000;
    err_total++;
    give_verdict;
  end
endmodule
